// *** core/afe_chan_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface afe_chan_if import afe_pkg::*; ();
	logic mod_tick;
	logic frame_tick;
	afe_sample_t analog_in;
	afe_sample_t result;
	logic [2:0] bitstream;
	modport ctrl (output mod_tick, frame_tick, analog_in, input result, bitstream);
	modport chan (input mod_tick, frame_tick, analog_in, output result, bitstream);
endinterface : afe_chan_if
`default_nettype wire

// *** core/afe_defs.svh ***
`ifndef AFE_DEFS_SVH
`define AFE_DEFS_SVH
// ****************************************
// Timing
// ****************************************
`define AFE_CLK_HZ 20000000
`define AFE_MOD_HZ 1000000
`define AFE_CONV_US 128
`define AFE_REFV_US 50
`define AFE_MOD_DIV (`AFE_CLK_HZ / `AFE_MOD_HZ)
`define AFE_CONV_SAMP (`AFE_CONV_US * `AFE_MOD_HZ / 1000000)
`define AFE_REFV_CYC ((`AFE_REFV_US * `AFE_CLK_HZ + 999999) / 1000000)
// ****************************************
// Scaling
// ****************************************
`define AFE_FS_NEG 24'h800000
`define AFE_FS_POS 24'h7fffff
`define AFE_FB_STEP 36'sh124925
`define AFE_DEC_GAIN 26'sh2493
`define AFE_Q_SHIFT 22
// ****************************************
// Fields and reset values
// ****************************************
`define AFE_APC_REFBUF_BIT 0
`define AFE_AMUX_TSE_BIT 0
`define AFE_REFBUF_RST 1'b0
`define AFE_BRG_RST 3'h1
`define AFE_TSRC_RST 1'b0
`define AFE_TSE_RST 1'b1
`define AFE_PGAIN_RST 5'h00
`define AFE_TGAIN_RST 2'h0
`endif

// *** core/afe_front_end_ctrl.sv ***
// What this block does
// [RULE1] Pressure modulator: 1 MHz, second order, 3-bit
// [RULE2] Temperature modulator: same 1 MHz second-order loop
// [RULE3] New pressure result every 128 us
// [RULE4] Pressure result is 24-bit two's complement
// [RULE5] Linear scale, 0x800000 to 0x7fffff
// [RULE6] New temperature result every 128 us
// [RULE7] Temperature uses identical 24-bit scaling
// [RULE8] Temperature result in two result registers
// [RULE9] Writing 0 disables reference buffer
// [RULE10] Reference buffer disabled after reset
// [RULE11] Reference valid 50 us after core start
// [RULE12] Bridge supply: 2.5 V, 2 V, 1.25 V
// [RULE13] Temperature source: internal or external pins
// [RULE14] Pressure gain: five-bit field
// [RULE15] Temperature gain: two-bit field
// [RULE16] Single-ended or differential, single-ended versus ground
// [RULE17] Internal sensor needs single-ended, 5 V/V; t_gain_select is not forced and no gain is applied
// [RULE18] Differential unless sensor terminal grounded
// [RULE19] Gain 20 V/V external, 5 V/V internal; t_gain_select is only stored, the result path applies no gain
// [RULE20] Result registers update together per conversion
`timescale 1ns/1ps
`default_nettype none
`include "afe_defs.svh"
module afe_front_end_ctrl import afe_pkg::*;
#(
	parameter int MOD_DIV = `AFE_MOD_DIV,
	parameter int CONV_SAMP = `AFE_CONV_SAMP,
	parameter int REFV_CYC = `AFE_REFV_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sampled analog inputs
	input wire afe_sample_t press_in,
	input wire afe_sample_t tsense_int_in,
	input wire afe_sample_t tsense_pos_in,
	input wire afe_sample_t tsense_neg_in,
	// Configuration writes
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_bridge_supply_select,
	input wire logic cfg_temp_source_select,
	input wire logic [4:0] cfg_p_gain_select,
	input wire logic [1:0] cfg_t_gain_select,
	input wire logic apc_wr,
	input wire logic [7:0] apc_wdata,
	input wire logic amux_wr,
	input wire logic [7:0] amux_wdata,
	// Configuration state
	output logic ref_buffer_en,
	output logic ref_valid,
	output logic [2:0] bridge_supply_select,
	output logic temp_source_select,
	output logic thermal_input_single_ended,
	output logic [4:0] p_gain_select,
	output logic [1:0] t_gain_select,
	// Result registers
	output afe_sample_t pressure_result_reg,
	output logic [15:0] thermal_result_reg_a,
	output logic [7:0] thermal_result_reg_b,
	// Result stream
	output logic res_valid,
	input wire logic res_ready,
	output afe_frame_s res_data,
	output logic res_overrun,
	input wire logic overrun_clear,
	// Modulator bitstreams
	output logic [2:0] press_bitstream,
	output logic [2:0] temp_bitstream
);
	// ****************************************
	// Parameter checks
	// ****************************************
	if (MOD_DIV < 2 || MOD_DIV > 256 || CONV_SAMP < 1 || CONV_SAMP > 128 ||
		REFV_CYC < 1 || REFV_CYC > 1023)
	begin : g_bad_param
		$error("afe_front_end_ctrl: unsupported parameter value");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	afe_sample_t pin_in [4];
	afe_sample_t sync1_reg [4];
	afe_sample_t sync2_reg [4];

	assign pin_in[0] = press_in;
	assign pin_in[1] = tsense_int_in;
	assign pin_in[2] = tsense_pos_in;
	assign pin_in[3] = tsense_neg_in;

	for (genvar i = 0; i < 4; i++)
	begin : g_sync
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				sync1_reg[i] <= '0;
				sync2_reg[i] <= '0;
			end
			else
			begin
				sync1_reg[i] <= pin_in[i];
				sync2_reg[i] <= sync1_reg[i];
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic brg_legal;
	logic [2:0] brg_onehot;

	assign brg_legal = cfg_bridge_supply_select != 2'b11;
	assign brg_onehot = (cfg_bridge_supply_select == AFE_BRG_2V5) ? 3'h1 :
		(cfg_bridge_supply_select == AFE_BRG_2V0) ? 3'h2 : 3'h4;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ref_buffer_en <= `AFE_REFBUF_RST; // [RULE10]
			bridge_supply_select <= `AFE_BRG_RST;
			temp_source_select <= `AFE_TSRC_RST;
			thermal_input_single_ended <= `AFE_TSE_RST;
			p_gain_select <= `AFE_PGAIN_RST;
			t_gain_select <= `AFE_TGAIN_RST;
		end
		else
		begin
			if (apc_wr)
				ref_buffer_en <= apc_wdata[`AFE_APC_REFBUF_BIT]; // [RULE9]
			if (amux_wr)
				thermal_input_single_ended <= amux_wdata[`AFE_AMUX_TSE_BIT]; // [RULE16]
			if (cfg_wr)
			begin
				if (brg_legal)
					bridge_supply_select <= brg_onehot; // [RULE12]
				temp_source_select <= cfg_temp_source_select; // [RULE13]
				p_gain_select <= cfg_p_gain_select; // [RULE14]
				t_gain_select <= cfg_t_gain_select; // [RULE15]
			end
		end
	end

	// ****************************************
	// Reference settle timer
	// ****************************************
	afe_ref_e ref_state_reg, ref_state_next;
	logic [9:0] refv_cnt_reg;
	logic refv_done;

	assign refv_done = refv_cnt_reg == 10'(REFV_CYC - 1);

	always_comb
	begin
		ref_state_next = ref_state_reg;
		unique case (ref_state_reg)
			AFE_REF_WAIT: if (refv_done) ref_state_next = AFE_REF_VALID; // [RULE11]
			AFE_REF_VALID: ref_state_next = AFE_REF_VALID;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ref_state_reg <= AFE_REF_WAIT;
			refv_cnt_reg <= '0;
			ref_valid <= 1'b0;
		end
		else
		begin
			ref_state_reg <= ref_state_next;
			if (ref_state_reg == AFE_REF_WAIT)
				refv_cnt_reg <= refv_cnt_reg + 10'h001;
			ref_valid <= ref_state_next == AFE_REF_VALID;
		end
	end

	// ****************************************
	// Modulator and frame timing
	// ****************************************
	logic [7:0] div_reg;
	logic [7:0] samp_reg;
	logic div_wrap, samp_wrap;
	logic mod_tick_reg, frame_tick_reg, frame_done_reg;

	assign div_wrap = div_reg == 8'(MOD_DIV - 1);
	assign samp_wrap = samp_reg == 8'(CONV_SAMP - 1);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_reg <= '0;
			samp_reg <= '0;
			mod_tick_reg <= 1'b0;
			frame_tick_reg <= 1'b0;
			frame_done_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_wrap ? 8'h00 : div_reg + 8'h01; // [RULE1] [RULE2]
			if (div_wrap)
				samp_reg <= samp_wrap ? 8'h00 : samp_reg + 8'h01;
			mod_tick_reg <= div_wrap;
			frame_tick_reg <= div_wrap && samp_wrap; // [RULE3] [RULE6]
			frame_done_reg <= frame_tick_reg;
		end
	end

	// ****************************************
	// Channel inputs and instances
	// ****************************************
	afe_sample_t tdiff_sat, thermal_ext, thermal_sel;
	logic signed [24:0] tdiff;

	assign tdiff = 25'(sync2_reg[2]) - 25'(sync2_reg[3]);
	assign tdiff_sat = (tdiff > 25'sh07fffff) ? `AFE_FS_POS :
		(tdiff < -25'sh0800000) ? `AFE_FS_NEG : tdiff[23:0];
	assign thermal_ext = thermal_input_single_ended ? sync2_reg[2] : tdiff_sat; // [RULE16]
	assign thermal_sel = (temp_source_select == AFE_TSRC_INT) ? sync2_reg[1] : thermal_ext; // [RULE13]

	afe_chan_if ch_if [2] ();
	afe_sample_t chan_in [2];

	assign chan_in[0] = sync2_reg[0];
	assign chan_in[1] = thermal_sel;

	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		assign ch_if[c].mod_tick = mod_tick_reg;
		assign ch_if[c].frame_tick = frame_tick_reg;
		assign ch_if[c].analog_in = chan_in[c];
		afe_sd_channel u_chan
		(
			.clk(clk),
			.rst(rst),
			.ch(ch_if[c])
		);
	end

	assign press_bitstream = ch_if[0].bitstream;
	assign temp_bitstream = ch_if[1].bitstream;

	// ****************************************
	// Result registers
	// ****************************************
	afe_frame_s frame_word;

	assign frame_word = '{press: ch_if[0].result, temp: ch_if[1].result};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pressure_result_reg <= '0;
			thermal_result_reg_a <= '0;
			thermal_result_reg_b <= '0;
		end
		else if (frame_done_reg)
		begin
			pressure_result_reg <= frame_word.press; // [RULE20]
			thermal_result_reg_a <= frame_word.temp[15:0]; // [RULE8]
			thermal_result_reg_b <= frame_word.temp[23:16];
		end
	end

	// ****************************************
	// Two-entry result buffer
	// ****************************************
	afe_frame_s tail_reg;
	logic tail_valid_reg;
	logic buf_in_ready, push, pop;

	assign buf_in_ready = !tail_valid_reg;
	assign push = frame_done_reg && buf_in_ready;
	assign pop = res_valid && res_ready;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			res_valid <= 1'b0;
			res_data <= '0;
			tail_reg <= '0;
			tail_valid_reg <= 1'b0;
			res_overrun <= 1'b0;
		end
		else
		begin
			if (pop)
			begin
				res_valid <= tail_valid_reg || push;
				res_data <= tail_valid_reg ? tail_reg : frame_word;
				tail_valid_reg <= 1'b0;
			end
			else if (push && res_valid)
			begin
				tail_reg <= frame_word;
				tail_valid_reg <= 1'b1;
			end
			else if (push)
			begin
				res_data <= frame_word;
				res_valid <= 1'b1;
			end
			if (frame_done_reg && !buf_in_ready)
				res_overrun <= 1'b1;
			else if (overrun_clear)
				res_overrun <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [11:0] gap_reg;
	logic gap_seen_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gap_reg <= '0;
			gap_seen_reg <= 1'b0;
		end
		else
		begin
			gap_reg <= frame_tick_reg ? 12'h000 : gap_reg + 12'h001;
			if (frame_tick_reg)
				gap_seen_reg <= 1'b1;
		end
	end

	sequence s_frame_end;
		frame_tick_reg ##1 frame_done_reg;
	endsequence

	sequence s_regs_loaded;
		pressure_result_reg == $past(ch_if[0].result) &&
			{thermal_result_reg_b, thermal_result_reg_a} == $past(ch_if[1].result);
	endsequence

	mod_period_a: assert property (mod_tick_reg |=> !mod_tick_reg [*8] ##12 mod_tick_reg) // [RULE1]
		else $error("modulator tick period is not 20 clocks");
	frame_period_a: assert property (frame_tick_reg && gap_seen_reg |-> gap_reg == 12'd2559) // [RULE3]
		else $error("conversion period is not 128 us");
	frame_on_tick_a: assert property (frame_tick_reg |-> mod_tick_reg) // [RULE6]
		else $error("frame end off the modulator tick");
	atomic_load_a: assert property (s_frame_end |=> s_regs_loaded) // [RULE20]
		else $error("result registers not loaded together");
	ref_off_a: assert property (apc_wr && !apc_wdata[`AFE_APC_REFBUF_BIT] |=> !ref_buffer_en) // [RULE9]
		else $error("reference buffer not disabled by write of 0");
	ref_reset_a: assert property ($fell(rst) |-> !ref_buffer_en) // [RULE10]
		else $error("reference buffer enabled after reset");
	ref_valid_a: assert property ($rose(ref_valid) |-> $past(refv_cnt_reg) == 10'(REFV_CYC - 1)) // [RULE11]
		else $error("reference valid not 50 us after start");
	bridge_hot_a: assert property ($onehot(bridge_supply_select)) // [RULE12]
		else $error("bridge supply select not one of three levels");
	overrun_set_a: assert property (frame_done_reg && tail_valid_reg && !pop |=> res_overrun)
		else $error("overrun lost");
endmodule : afe_front_end_ctrl
`default_nettype wire

// *** core/afe_pkg.sv ***
package afe_pkg;
	typedef logic signed [23:0] afe_sample_t;
	typedef enum logic [1:0] {AFE_BRG_2V5 = 2'b00, AFE_BRG_2V0 = 2'b01, AFE_BRG_1V25 = 2'b10} afe_brg_e;
	typedef enum logic {AFE_TSRC_INT = 1'b0, AFE_TSRC_EXT = 1'b1} afe_tsrc_e;
	typedef enum logic {AFE_REF_WAIT = 1'b0, AFE_REF_VALID = 1'b1} afe_ref_e;
	typedef struct packed
	{
		afe_sample_t press;
		afe_sample_t temp;
	} afe_frame_s;
endpackage : afe_pkg

// *** core/afe_sd_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afe_defs.svh"
module afe_sd_channel import afe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control side
	afe_chan_if.chan ch
);
	// ****************************************
	// Second-order loop, 3-bit quantizer
	// ****************************************
	logic signed [35:0] int1_reg, int2_reg, int1_next, int2_next, fb, q_raw;
	logic signed [2:0] q_reg, q_next;
	logic signed [3:0] level;
	logic signed [10:0] acc_reg, sum_next;
	logic signed [25:0] prod;
	afe_sample_t result_reg, result_next;

	assign level = $signed({q_reg, 1'b1});
	assign fb = 36'(level) * `AFE_FB_STEP;
	assign int1_next = int1_reg + 36'(ch.analog_in) - fb;
	assign int2_next = int2_reg + int1_next - (fb <<< 1);
	assign q_raw = int2_next >>> `AFE_Q_SHIFT;
	assign q_next = (q_raw > 36'sd3) ? 3'sd3 : (q_raw < -36'sd4) ? -3'sd4 : q_raw[2:0];

	// ****************************************
	// Decimation to 24-bit signed
	// ****************************************
	assign sum_next = acc_reg + 11'(level);
	assign prod = 26'(sum_next) * `AFE_DEC_GAIN;
	assign result_next = (prod > $signed({2'b00, `AFE_FS_POS})) ? `AFE_FS_POS :
		(prod < $signed({2'b11, `AFE_FS_NEG})) ? `AFE_FS_NEG : prod[23:0];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			int1_reg <= '0;
			int2_reg <= '0;
			q_reg <= '0;
			acc_reg <= '0;
			result_reg <= '0;
		end
		else if (ch.mod_tick)
		begin
			int1_reg <= int1_next; // [RULE1] [RULE2]
			int2_reg <= int2_next;
			q_reg <= q_next;
			acc_reg <= ch.frame_tick ? 11'sd0 : sum_next;
			if (ch.frame_tick)
				result_reg <= result_next; // [RULE4] [RULE5] [RULE7]
		end
	end

	assign ch.result = result_reg;
	assign ch.bitstream = q_reg;

	sat_top_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
		(ch.mod_tick && ch.frame_tick && sum_next == 11'sd896) |=> ch.result == `AFE_FS_POS)
		else $error("full-scale sum did not give top code");
	sat_bottom_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
		(ch.mod_tick && ch.frame_tick && sum_next == -11'sd896) |=> ch.result == `AFE_FS_NEG)
		else $error("full-scale negative sum did not give bottom code");
endmodule : afe_sd_channel
`default_nettype wire

// *** verif/afe_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bridge and temperature sense elements
// ****************************************
module afe_sensor_model import afe_pkg::*;
(
	// Clock and bridge excitation
	input wire logic clk,
	input wire logic [2:0] bridge_sel,
	// Element levels at 2.5 V excitation
	input wire afe_sample_t p_level,
	input wire afe_sample_t t_int_level,
	input wire afe_sample_t t_pos_level,
	input wire afe_sample_t t_neg_level,
	// Sensed values
	output var afe_sample_t press_out,
	output var afe_sample_t t_int_out,
	output var afe_sample_t t_pos_out,
	output var afe_sample_t t_neg_out
);
	int p_scaled;
	// Bridge output is ratiometric to the selected excitation
	assign p_scaled = (bridge_sel == 3'h2) ? (int'(p_level) * 4) / 5 :
		(bridge_sel == 3'h4) ? int'(p_level) / 2 : int'(p_level);
	initial
	begin
		press_out = '0;
		t_int_out = '0;
		t_pos_out = '0;
		t_neg_out = '0;
		forever
		begin
			@(negedge clk);
			press_out = afe_sample_t'(p_scaled);
			t_int_out = t_int_level;
			t_pos_out = t_pos_level;
			t_neg_out = t_neg_level;
		end
	end
endmodule : afe_sensor_model
`default_nettype wire

// *** verif/tb_sensor_adc_front_end_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_sensor_adc_front_end_control import afe_pkg::*;;
	// ****************************************
	// Signals
	// ****************************************
	localparam int CYC_MAX = 50000;
	localparam logic [1:0] T_GAIN_5 = 2'h1;
	localparam logic [1:0] T_GAIN_20 = 2'h3;
	localparam int TOL = 37452;
	logic clk, rst;
	logic cfg_wr = 1'b0, apc_wr = 1'b0, amux_wr = 1'b0, cfg_temp_source_select = 1'b0;
	logic res_ready = 1'b1, overrun_clear = 1'b0;
	logic [1:0] cfg_bridge_supply_select = 2'h0, cfg_t_gain_select = 2'h0;
	logic [4:0] cfg_p_gain_select = 5'h00;
	logic [7:0] apc_wdata = 8'h00, amux_wdata = 8'h00;
	afe_sample_t p_level = '0, t_int_level = '0, t_pos_level = '0, t_neg_level = '0;
	afe_sample_t press_in, tsense_int_in, tsense_pos_in, tsense_neg_in, pressure_result_reg;
	logic ref_buffer_en, ref_valid, temp_source_select, thermal_input_single_ended;
	logic res_valid, res_overrun;
	logic [2:0] bridge_supply_select, press_bitstream, temp_bitstream;
	logic [4:0] p_gain_select;
	logic [1:0] t_gain_select;
	logic [15:0] thermal_result_reg_a;
	logic [7:0] thermal_result_reg_b;
	afe_frame_s res_data, fr;
	int err_total = 0, checks = 0, cyc = 0;
	time t_prev, t_now;

	afe_sensor_model u_sensor (.clk(clk), .bridge_sel(bridge_supply_select),
		.p_level(p_level), .t_int_level(t_int_level), .t_pos_level(t_pos_level),
		.t_neg_level(t_neg_level), .press_out(press_in), .t_int_out(tsense_int_in),
		.t_pos_out(tsense_pos_in), .t_neg_out(tsense_neg_in));

	afe_front_end_ctrl u_dut (.clk(clk), .rst(rst), .press_in(press_in),
		.tsense_int_in(tsense_int_in), .tsense_pos_in(tsense_pos_in),
		.tsense_neg_in(tsense_neg_in), .cfg_wr(cfg_wr),
		.cfg_bridge_supply_select(cfg_bridge_supply_select),
		.cfg_temp_source_select(cfg_temp_source_select), .cfg_p_gain_select(cfg_p_gain_select),
		.cfg_t_gain_select(cfg_t_gain_select), .apc_wr(apc_wr), .apc_wdata(apc_wdata),
		.amux_wr(amux_wr), .amux_wdata(amux_wdata), .ref_buffer_en(ref_buffer_en),
		.ref_valid(ref_valid), .bridge_supply_select(bridge_supply_select),
		.temp_source_select(temp_source_select),
		.thermal_input_single_ended(thermal_input_single_ended),
		.p_gain_select(p_gain_select), .t_gain_select(t_gain_select),
		.pressure_result_reg(pressure_result_reg), .thermal_result_reg_a(thermal_result_reg_a),
		.thermal_result_reg_b(thermal_result_reg_b), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data), .res_overrun(res_overrun),
		.overrun_clear(overrun_clear), .press_bitstream(press_bitstream),
		.temp_bitstream(temp_bitstream));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == CYC_MAX)
		begin
			err_total++;
			end_sim();
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic bit near(input afe_sample_t a, input afe_sample_t e);
		integer d;
		d = a - e;
		return (d < TOL) && (d > -TOL);
	endfunction : near

	task automatic end_sim();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic wr_cfg(input logic [1:0] b, input logic s, input logic [4:0] pg,
		input logic [1:0] tg);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_bridge_supply_select = b;
		cfg_temp_source_select = s;
		cfg_p_gain_select = pg;
		cfg_t_gain_select = tg;
		@(negedge clk);
		cfg_wr = 1'b0;
		@(negedge clk);
	endtask : wr_cfg

	task automatic wr_reg(input bit to_amux, input logic [7:0] d);
		@(negedge clk);
		apc_wr = !to_amux;
		amux_wr = to_amux;
		apc_wdata = d;
		amux_wdata = d;
		@(negedge clk);
		apc_wr = 1'b0;
		amux_wr = 1'b0;
		@(negedge clk);
	endtask : wr_reg

	task automatic wait_frame();
		int n;
		n = 0;
		@(negedge clk);
		while (res_valid !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		`CHK(res_valid, 1'b1)
		fr = res_data;
		t_prev = t_now;
		t_now = $time;
	endtask : wait_frame
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		`CHK(ref_buffer_en, 1'b0)
		`CHK(bridge_supply_select, 3'h1)
		`CHK(thermal_input_single_ended, 1'b1)
		`CHK(press_bitstream, 3'h0)
		`CHK(temp_bitstream, 3'h0)
		repeat (999) @(negedge clk);
		`CHK(ref_valid, 1'b0)
		@(negedge clk);
		`CHK(ref_valid, 1'b1)
	endtask : t_reset

	task automatic t_config();
		logic [2:0] hot [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
		logic [1:0] tg [4] = '{2'h1, 2'h2, 2'h1, 2'h0};
		for (int i = 0; i < 4; i++)
		begin
			wr_cfg(2'(i), i[0], (i == 3) ? 5'h1f : 5'(i), tg[i]);
			`CHK(bridge_supply_select, hot[i])
			`CHK(temp_source_select, i[0])
			`CHK(p_gain_select, (i == 3) ? 5'h1f : 5'(i))
			`CHK(t_gain_select, tg[i])
		end
		wr_reg(1'b0, 8'h01);
		`CHK(ref_buffer_en, 1'b1)
		wr_reg(1'b0, 8'hfe);
		`CHK(ref_buffer_en, 1'b0)
		wr_reg(1'b1, 8'h00);
		`CHK(thermal_input_single_ended, 1'b0)
	endtask : t_config

	task automatic t_press_int();
		p_level = 24'sh3fffff;
		t_int_level = 24'shc00000;
		wr_reg(1'b1, 8'h01);
		wr_cfg(2'h0, 1'b0, 5'h00, T_GAIN_5);
		repeat (3) wait_frame();
		`CHK(t_now - t_prev, 64'd128000)
		`CHK(near(fr.press, 24'sh3fffff), 1'b1)
		`CHK(near(fr.temp, 24'shc00000), 1'b1)
		`CHK(pressure_result_reg, fr.press)
		`CHK({thermal_result_reg_b, thermal_result_reg_a}, fr.temp)
	endtask : t_press_int

	task automatic t_ext_modes();
		p_level = 24'shc00000;
		t_pos_level = 24'sh200000;
		t_neg_level = '0;
		wr_cfg(2'h2, 1'b1, 5'h1f, T_GAIN_20);
		wr_reg(1'b1, 8'h01);
		repeat (3) wait_frame();
		`CHK(near(fr.press, 24'she00000), 1'b1)
		`CHK(near(fr.temp, 24'sh200000), 1'b1)
		p_level = '0;
		t_neg_level = 24'sh100000;
		wr_cfg(2'h0, 1'b1, 5'h1f, T_GAIN_20);
		wr_reg(1'b1, 8'h00);
		repeat (3) wait_frame();
		`CHK(near(fr.press, 24'sh000000), 1'b1)
		`CHK(near(fr.temp, 24'sh100000), 1'b1)
	endtask : t_ext_modes

	task automatic t_overrun();
		`CHK(res_overrun, 1'b0)
		@(negedge clk);
		res_ready = 1'b0;
		wait_frame();
		repeat (6400) @(negedge clk);
		`CHK(res_overrun, 1'b1)
		`CHK(res_data, fr)
		res_ready = 1'b1;
		@(negedge clk);
		`CHK(res_valid, 1'b1)
		`CHK(near(res_data.press, 24'sh000000), 1'b1)
		`CHK(near(res_data.temp, 24'sh100000), 1'b1)
		@(negedge clk);
		res_ready = 1'b0;
		overrun_clear = 1'b1;
		`CHK(res_valid, 1'b0)
		@(negedge clk);
		overrun_clear = 1'b0;
		res_ready = 1'b1;
		@(negedge clk);
		`CHK(res_overrun, 1'b0)
	endtask : t_overrun
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_config();
		t_press_int();
		t_ext_modes();
		t_overrun();
		end_sim();
	end
endmodule : tb_sensor_adc_front_end_control
`default_nettype wire
